// >>> logic/flash_addr_map.sv
// uniform sector and block decode with block protection check
`timescale 1ns/1ps
module flash_addr_map
    import flash_front_pkg::*;
(
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic              density64,
    input  wire logic [7:0]        protBlocks,
    input  wire logic              protBottom,
    output addr_info_t             info
);

    logic [7:0]        blkCount;
    logic [7:0]        blkIdx;
    logic [ADDR_W-1:0] topAddr;

    always_comb begin
        blkCount = density64 ? BLOCKS_64M : BLOCKS_32M;
        topAddr  = density64 ? TOP_ADDR_64M : TOP_ADDR_32M;
        blkIdx   = addr[ADDR_W-1:BLK64_LOG2];
        info.sector  = addr[ADDR_W-1:SECTOR_LOG2];
        info.block32 = addr[ADDR_W-1:BLK32_LOG2];
        info.block64 = addr[ADDR_W-1:BLK64_LOG2];
        info.inRange = (addr <= topAddr);
        if (protBottom) begin
            info.isProtected = (blkIdx < protBlocks);
        end else begin
            info.isProtected = (protBlocks != 8'h00) && (blkIdx >= 8'(blkCount - protBlocks));
        end
    end

endmodule

// >>> logic/flash_front_pkg.sv
// shared constants and carrier types for the serial flash pin front end
package flash_front_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // address map
    localparam int          ADDR_W        = 24;
    localparam int          SECTOR_LOG2   = 12;
    localparam int          BLK32_LOG2    = 15;
    localparam int          BLK64_LOG2    = 16;
    localparam int          SECTOR_W      = ADDR_W - SECTOR_LOG2;
    localparam int          BLK32_W       = ADDR_W - BLK32_LOG2;
    localparam int          BLK64_W       = ADDR_W - BLK64_LOG2;
    localparam logic [23:0] TOP_ADDR_64M  = 24'h7fffff;
    localparam logic [23:0] TOP_ADDR_32M  = 24'h3fffff;
    localparam logic [7:0]  BLOCKS_64M    = 8'h80;
    localparam logic [7:0]  BLOCKS_32M    = 8'h40;

    ////////////////////////////////////////////////////////////////////////////
    // serial lanes
    localparam int          LINE_CNT      = 4;
    localparam int          LINE_SI       = 0;
    localparam int          LINE_SO       = 1;
    localparam int          LINE_WP       = 2;
    localparam int          LINE_HOLD     = 3;
    localparam int          BYTE_W        = 8;
    localparam logic [2:0]  STEP_SINGLE   = 3'h1;
    localparam logic [2:0]  STEP_QUAD     = 3'h4;
    localparam logic [2:0]  BIT_CNT_RST   = 3'h0;
    localparam logic [3:0]  OE_NONE       = 4'h0;
    localparam logic [3:0]  OE_SINGLE     = 4'h2;
    localparam logic [3:0]  OE_QUAD       = 4'hf;

    ////////////////////////////////////////////////////////////////////////////
    // carriers
    typedef struct packed {
        logic       ceN;
        logic       resetN;
        logic [3:0] line;
    } pin_in_t;

    typedef struct packed {
        logic [3:0] data;
        logic [3:0] oe;
    } pin_out_t;

    typedef struct packed {
        logic [SECTOR_W-1:0] sector;
        logic [BLK32_W-1:0]  block32;
        logic [BLK64_W-1:0]  block64;
        logic                inRange;
        logic                isProtected;
    } addr_info_t;

    typedef struct packed {
        logic quadEnableBit;
        logic fourLineCommandMode;
        logic wideData;
    } lane_cfg_t;

    typedef enum logic [1:0] {
        TX_IDLE = 2'b01,
        TX_WAIT = 2'b10
    } tx_state_t;

endpackage

// >>> logic/serial_flash_pin_front_end.sv
// serial flash pin front end: lane mapping, hold, reset, clock domain crossing
`timescale 1ns/1ps
module serial_flash_pin_front_end
    import flash_front_pkg::*;
#(
    parameter bit DEDICATED_RESET = 1'b1
) (
    input  wire logic              clk,
    input  wire logic              sys_rst,
    input  wire logic              sck,
    input  wire pin_in_t           pinIn,
    output pin_out_t               pinOut,
    input  wire lane_cfg_t         laneCfg,
    output logic [BYTE_W-1:0]      rxData,
    output logic                   rxValid,
    input  wire logic [BYTE_W-1:0] txData,
    input  wire logic              txValid,
    output logic                   txReady,
    input  wire logic [ADDR_W-1:0] checkAddr,
    input  wire logic              density64,
    input  wire logic [7:0]        protBlocks,
    input  wire logic              protBottom,
    output addr_info_t             addrInfo,
    output logic                   selected,
    output logic                   inReset
);

    ////////////////////////////////////////////////////////////////////////////
    // link side resets

    logic      resetPinN;
    logic      linkRst;
    logic      frameRst;
    lane_cfg_t cfgLink;
    logic      holdActive;
    logic      quadLanes;
    logic [2:0] step;

    assign resetPinN = DEDICATED_RESET ? pinIn.resetN : 1'b1;
    // reset pin forces the link logic
    assign linkRst   = sys_rst | ~resetPinN;
    assign frameRst  = linkRst | pinIn.ceN;

    // configuration is quasi-static; change it only between frames
    sync_level #(.W(3)) u_cfgSync (
        .clk (sck),
        .rst (linkRst),
        .d   (laneCfg),
        .q   (cfgLink)
    );

    // hold works only with quad bit and four-line mode both clear
    assign holdActive = ~cfgLink.quadEnableBit & ~cfgLink.fourLineCommandMode
                        & ~pinIn.line[LINE_HOLD] & ~pinIn.ceN;
    // four-line mode widens to all lines
    assign quadLanes  = cfgLink.fourLineCommandMode | (cfgLink.quadEnableBit & cfgLink.wideData);
    assign step       = quadLanes ? STEP_QUAD : STEP_SINGLE;

    ////////////////////////////////////////////////////////////////////////////
    // receive shifter on rising edge

    logic [BYTE_W-1:0] rxShift_q;
    logic [BYTE_W-1:0] rxShift_d;
    logic [2:0]        rxCnt_q;
    logic [2:0]        rxCntNext;
    logic [BYTE_W-1:0] rxWord_q;
    logic              rxTog_q;

    always_comb begin
        rxCntNext = 3'(rxCnt_q + step);
        if (quadLanes) begin
            rxShift_d = {rxShift_q[BYTE_W-5:0], pinIn.line};
        end else begin
            rxShift_d = {rxShift_q[BYTE_W-2:0], pinIn.line[LINE_SI]};
        end
    end

    always_ff @(posedge sck or posedge frameRst) begin
        if (frameRst) begin
            rxShift_q <= '0;
            rxCnt_q   <= BIT_CNT_RST;
        end else if (!holdActive) begin
            rxShift_q <= rxShift_d;
            rxCnt_q   <= rxCntNext;
        end
    end

    // word and toggle survive deselect so the other side can fetch them
    always_ff @(posedge sck or posedge linkRst) begin
        if (linkRst) begin
            rxWord_q <= '0;
            rxTog_q  <= 1'b0;
        end else if (!pinIn.ceN && !holdActive && rxCntNext == BIT_CNT_RST) begin
            rxWord_q <= rxShift_d;
            rxTog_q  <= ~rxTog_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // transmit shifter on falling edge

    logic              txReqTog_q;
    logic              txReqSync;
    logic [BYTE_W-1:0] txWord_q;
    logic [BYTE_W-1:0] txShift_q;
    logic [2:0]        txCnt_q;
    logic              txLoaded_q;
    logic              txAckTog_q;
    logic              txPending;

    sync_level #(.W(1)) u_reqSync (
        .clk (sck),
        .rst (linkRst),
        .d   (txReqTog_q),
        .q   (txReqSync)
    );

    assign txPending = (txReqSync != txAckTog_q);

    always_ff @(negedge sck or posedge frameRst) begin
        if (frameRst) begin
            txShift_q  <= '0;
            txCnt_q    <= BIT_CNT_RST;
            txLoaded_q <= 1'b0;
        end else if (!holdActive) begin
            if (txLoaded_q && 3'(txCnt_q + step) != BIT_CNT_RST) begin
                txShift_q <= quadLanes ? {txShift_q[BYTE_W-5:0], 4'h0}
                                       : {txShift_q[BYTE_W-2:0], 1'b0};
                txCnt_q   <= 3'(txCnt_q + step);
            end else if (txPending) begin
                txShift_q  <= txWord_q;
                txCnt_q    <= BIT_CNT_RST;
                txLoaded_q <= 1'b1;
            end else begin
                txLoaded_q <= 1'b0;
                txCnt_q    <= BIT_CNT_RST;
            end
        end
    end

    always_ff @(negedge sck or posedge linkRst) begin
        if (linkRst) begin
            txAckTog_q <= 1'b0;
        end else if (!pinIn.ceN && !holdActive && txPending
                     && !(txLoaded_q && 3'(txCnt_q + step) != BIT_CNT_RST)) begin
            txAckTog_q <= txReqSync;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pin drivers

    logic [3:0] oeSel;

    always_comb begin
        oeSel = quadLanes ? OE_QUAD : OE_SINGLE;
        pinOut.data = quadLanes ? txShift_q[BYTE_W-1:BYTE_W-4]
                                : {2'b00, txShift_q[BYTE_W-1], 1'b0};
        if (pinIn.ceN || !resetPinN || sys_rst || holdActive || !txLoaded_q) begin
            pinOut.oe = OE_NONE;
        end else begin
            pinOut.oe = oeSel;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // system side crossing

    logic [2:0]   statSync;
    logic         rxTogSync;
    logic         rxTogSeen_q;
    logic         txAckSync;
    logic         armed_q;
    logic [1:0]   fill_q;
    tx_state_t    txState_q;

    sync_level #(.W(3)) u_statSync (
        .clk (clk),
        .rst (sys_rst),
        .d   ({~pinIn.ceN, ~resetPinN, rxTog_q}),
        .q   (statSync)
    );

    sync_level #(.W(1)) u_ackSync (
        .clk (clk),
        .rst (sys_rst),
        .d   (txAckTog_q),
        .q   (txAckSync)
    );

    assign rxTogSync = statSync[0];

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            selected <= 1'b0;
            inReset  <= 1'b0;
        end else begin
            selected <= statSync[2];
            inReset  <= statSync[1];
        end
    end

    // synchroniser reset value reads as deselected; wait for real samples
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            fill_q <= '0;
        end else begin
            fill_q <= {fill_q[0], 1'b1};
        end
    end

    // arm only after a deselected phase
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            armed_q <= 1'b0;
        end else if (statSync[1]) begin
            armed_q <= 1'b0;
        end else if (!statSync[2] && fill_q[1]) begin
            armed_q <= 1'b1;
        end
    end

    // received word is stable for two sck periods after the toggle
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rxTogSeen_q <= 1'b0;
            rxValid     <= 1'b0;
            rxData      <= '0;
        end else begin
            rxTogSeen_q <= rxTogSync;
            rxValid     <= 1'b0;
            if (statSync[1]) begin
                rxTogSeen_q <= 1'b0;
            end else if (rxTogSync != rxTogSeen_q && armed_q) begin
                rxValid <= 1'b1;
                rxData  <= rxWord_q;
            end
        end
    end

    assign txReady = (txState_q == TX_IDLE) && !statSync[1];

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            txState_q  <= TX_IDLE;
            txReqTog_q <= 1'b0;
            txWord_q   <= '0;
        end else if (statSync[1]) begin
            txState_q  <= TX_IDLE;
            txReqTog_q <= 1'b0;
        end else begin
            unique case (txState_q)
                TX_IDLE: begin
                    if (txValid) begin
                        txWord_q   <= txData;
                        txReqTog_q <= ~txReqTog_q;
                        txState_q  <= TX_WAIT;
                    end
                end
                TX_WAIT: begin
                    if (txAckSync == txReqTog_q) begin
                        txState_q <= TX_IDLE;
                    end
                end
                default: begin
                    txState_q <= TX_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // address map

    addr_info_t mapInfo;

    flash_addr_map u_addrMap (
        .addr       (checkAddr),
        .density64  (density64),
        .protBlocks (protBlocks),
        .protBottom (protBottom),
        .info       (mapInfo)
    );

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            addrInfo <= '0;
        end else begin
            addrInfo <= mapInfo;
        end
    end

endmodule

// >>> logic/sync_level.sv
// two flip-flop level synchroniser
`timescale 1ns/1ps
module sync_level
    import flash_front_pkg::*;
#(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    logic [W-1:0] meta_q;

    // first stage is read only by the second
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_q <= '0;
            q      <= '0;
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end

endmodule

// >>> sim/front_end_props.sv
// concurrent checks on the flash front end ports
`timescale 1ns/1ps
module front_end_props
    import flash_front_pkg::*;
(
    input wire logic              clk,
    input wire logic              sys_rst,
    input wire pin_in_t           pinIn,
    input wire pin_out_t          pinOut,
    input wire lane_cfg_t         laneCfg,
    input wire logic              rxValid,
    input wire logic              txValid,
    input wire logic              txReady,
    input wire logic [ADDR_W-1:0] checkAddr,
    input wire logic              density64,
    input wire addr_info_t        addrInfo,
    input wire logic              selected,
    input wire logic              inReset
);
    default clocking dc @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    logic [ADDR_W-1:0] topAddr;
    assign topAddr = density64 ? TOP_ADDR_64M : TOP_ADDR_32M;

    ////////////////////////////////////////
    a_desel_float: assert property (pinIn.ceN |-> pinOut.oe == OE_NONE)
        else $error("lines driven while deselected");
    a_hold_float: assert property (!pinIn.ceN && !pinIn.line[LINE_HOLD] && !laneCfg.quadEnableBit
        && !laneCfg.fourLineCommandMode |-> !pinOut.oe[LINE_SO])
        else $error("output driven during hold");
    a_pin_float: assert property (!pinIn.resetN |-> pinOut.oe == OE_NONE)
        else $error("lines driven in pin reset");
    a_reset_seen: assert property (!pinIn.resetN [*4] |-> inReset && !txReady)
        else $error("pin reset not seen");
    a_select_sync: assert property ($stable(pinIn.ceN) [*4] |-> selected == !pinIn.ceN)
        else $error("selected does not follow chip enable");
    a_tx_take: assert property (txValid && txReady |=> !txReady)
        else $error("byte taken but still ready");
    a_rx_pulse: assert property (rxValid |=> !rxValid)
        else $error("receive strobe longer than one cycle");
    a_block_nest: assert property (addrInfo.block32 == addrInfo.sector[11:3]
        && addrInfo.block64 == addrInfo.sector[11:4])
        else $error("blocks do not group sectors");
    // stable inputs only: the decode is registered
    a_sector_span: assert property (!$past(sys_rst) && $stable(checkAddr)
        |-> addrInfo.sector == checkAddr[23:12])
        else $error("sector number wrong");
    a_range_top: assert property (!$past(sys_rst) && $stable(checkAddr) && $stable(density64)
        |-> addrInfo.inRange == (checkAddr <= topAddr))
        else $error("range flag wrong");
endmodule

// >>> sim/serial_flash_pin_front_end_bench.sv
// self-checking bench for the serial flash pin front end
`timescale 1ns/1ps
`define CHK(nm, e, s) begin checksDone++; if ((s) !== (e)) begin nFail++; $display("mismatch %s exp %h got %h", nm, e, s); end end
module serial_flash_pin_front_end_bench
    import flash_front_pkg::*;
;
    logic        clk;
    logic        sys_rst;
    logic        resetN;
    lane_cfg_t   laneCfg;
    logic [7:0]  txData;
    logic        txValid;
    logic [23:0] checkAddr;
    logic        density64;
    logic [7:0]  protBlocks;
    logic        protBottom;
    logic        sck;
    logic        ceN;
    logic [3:0]  drv;
    logic [3:0]  drvOe;
    logic [3:0]  lineLvl;
    pin_in_t     pinIn;
    pin_out_t    pinOut;
    addr_info_t  addrInfo;
    logic [7:0]  rxData;
    logic        rxValid;
    logic        txReady;
    logic        selected;
    logic        inReset;
    int          nFail;
    int          checksDone;
    int          cycles;
    logic [23:0] aTab [5] = '{24'h7ff123, 24'h000fff, 24'h3ff000, 24'h400000, 24'h010000};
    logic [4:0]  dTab = 5'b10011;

    // released lines read high, as through pull-ups
    assign lineLvl = (pinOut.oe & pinOut.data) | (~pinOut.oe & ((drvOe & drv) | ~drvOe));
    assign pinIn   = {ceN, resetN, lineLvl};

    serial_flash_pin_front_end u_dut (
        .clk        (clk),
        .sys_rst    (sys_rst),
        .sck        (sck),
        .pinIn      (pinIn),
        .pinOut     (pinOut),
        .laneCfg    (laneCfg),
        .rxData     (rxData),
        .rxValid    (rxValid),
        .txData     (txData),
        .txValid    (txValid),
        .txReady    (txReady),
        .checkAddr  (checkAddr),
        .density64  (density64),
        .protBlocks (protBlocks),
        .protBottom (protBottom),
        .addrInfo   (addrInfo),
        .selected   (selected),
        .inReset    (inReset)
    );

    spi_master_model m (.sck(sck), .ceN(ceN), .drv(drv), .drvOe(drvOe), .line(lineLvl));

    ////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic conclude();
        $display("checks %0d mismatches %0d", checksDone, nFail);
        if (nFail == 0 && checksDone > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            nFail++;
            conclude();
        end
    end

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic waitRx();
        for (int k = 0; k < 30 && rxValid !== 1'b1; k++) step(1);
    endtask

    task automatic frame(input bit pol, input bit quad, input logic [7:0] b);
        step(1);
        m.cpol = pol;
        m.sel();
        m.xfer(b, quad ? 2 : 8, quad);
        waitRx();
        m.desel();
    endtask

    ////////////////////////////////////////
    task automatic tHold();
        step(1);
        m.sel();
        m.xfer(8'ha5, 4, 1'b0);
        m.hold(1'b0);
        m.xfer(8'ha0, 4, 1'b0);
        m.hold(1'b1);
        m.xfer(8'h50, 4, 1'b0);
        waitRx();
        `CHK("selected", 1'b1, selected)
        m.desel();
        `CHK("held byte", 8'ha5, rxData)
    endtask

    task automatic tQeHold();
        step(1);
        m.sel();
        m.hold(1'b0);
        m.xfer(8'h96, 8, 1'b0);
        waitRx();
        m.hold(1'b1);
        m.desel();
        `CHK("hold ignored", 8'h96, rxData)
    endtask

    task automatic tTx();
        logic [7:0] got;
        @(posedge clk);
        txData  <= 8'h4b;
        txValid <= 1'b1;
        @(posedge clk);
        txValid <= 1'b0;
        step(1);
        m.cpol = 1'b1;
        m.sel();
        repeat (3) m.xfer(8'hff, 8, 1'b0);
        m.desel();
        got = 8'hff;
        for (int i = 23; i >= 7; i--)
            if (m.cap[i] === 1'b0 && got === 8'hff) got = m.cap[i -: 8];
        `CHK("tx byte", 8'h4b, got)
        step(5);
        `CHK("txReady", 1'b1, txReady)
    endtask

    task automatic tAddr();
        logic [23:0] a;
        logic        d;
        logic        pe;
        for (int i = 0; i < 5; i++) begin
            a = aTab[i];
            d = dTab[i];
            @(posedge clk);
            checkAddr  <= a;
            density64  <= d;
            protBottom <= (i == 1);
            step(2);
            pe = (i == 1) ? a[23:16] < protBlocks : a[23:16] >= (d ? BLOCKS_64M : BLOCKS_32M) - protBlocks;
            `CHK("sector", a[23:12], addrInfo.sector)
            `CHK("block64", a[23:16], addrInfo.block64)
            `CHK("inRange", a <= (d ? TOP_ADDR_64M : TOP_ADDR_32M), addrInfo.inRange)
            if (i != 3) `CHK("protected", pe, addrInfo.isProtected)
        end
    endtask

    // pulsed only while no internal write runs
    task automatic tPinReset();
        @(posedge clk);
        resetN <= 1'b0;
        step(5);
        `CHK("inReset", 1'b1, inReset)
        `CHK("oe", OE_NONE, pinOut.oe)
        @(posedge clk);
        resetN <= 1'b1;
        step(5);
        `CHK("inReset", 1'b0, inReset)
    endtask

    ////////////////////////////////////////
    initial begin
        sys_rst    = 1'b1;
        resetN     = 1'b1;
        laneCfg    = '0;
        txData     = 8'h00;
        txValid    = 1'b0;
        checkAddr  = 24'h000000;
        density64  = 1'b1;
        protBlocks = 8'h02;
        protBottom = 1'b0;
        fork
            m.tick(1);
            repeat (6) @(posedge clk);
        join
        sys_rst <= 1'b0;
        step(4);
        `CHK("txReady", 1'b1, txReady)
        `CHK("oe", OE_NONE, pinOut.oe)
        frame(1'b0, 1'b0, 8'ha5);
        `CHK("mode0 byte", 8'ha5, rxData)
        frame(1'b1, 1'b0, 8'hc3);
        `CHK("mode3 byte", 8'hc3, rxData)
        step(1);
        m.cpol = 1'b0;
        m.sel();
        m.xfer(8'hff, 3, 1'b0);
        m.desel();
        frame(1'b0, 1'b0, 8'h3c);
        `CHK("after abort", 8'h3c, rxData)
        tHold();
        tTx();
        tAddr();
        @(posedge clk);
        laneCfg <= 3'b100;
        m.tick(2);
        tQeHold();
        @(posedge clk);
        laneCfg <= 3'b101;
        m.tick(2);
        frame(1'b0, 1'b1, 8'h5a);
        `CHK("quad byte", 8'h5a, rxData)
        tPinReset();
        @(posedge clk);
        laneCfg <= 3'b010;
        m.tick(2);
        frame(1'b0, 1'b1, 8'h3c);
        `CHK("four-line byte", 8'h3c, rxData)
        conclude();
    end
endmodule

bind serial_flash_pin_front_end front_end_props u_props (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .pinIn     (pinIn),
    .pinOut    (pinOut),
    .laneCfg   (laneCfg),
    .rxValid   (rxValid),
    .txValid   (txValid),
    .txReady   (txReady),
    .checkAddr (checkAddr),
    .density64 (density64),
    .addrInfo  (addrInfo),
    .selected  (selected),
    .inReset   (inReset)
);

// >>> sim/spi_master_model.sv
// behavioural serial master driving the flash pins
`timescale 1ns/1ps
module spi_master_model (
    output logic            sck,
    output logic            ceN,
    output logic [3:0]      drv,
    output logic [3:0]      drvOe,
    input  wire logic [3:0] line
);
    bit          cpol = 1'b0;
    logic [23:0] cap;

    initial begin
        sck   = 1'b0;
        ceN   = 1'b1;
        drv   = 4'hf;
        drvOe = 4'h0;
        cap   = '0;
    end

    ////////////////////////////////////////
    // clock pulses with chip enable high, only to let settings cross
    task automatic tick(input int n);
        #3;
        repeat (n) begin
            #15 sck = ~sck;
            #15 sck = ~sck;
        end
    endtask

    task automatic sel();
        #3;
        sck   = cpol;
        #3;
        ceN   = 1'b0;
        drv   = 4'hf;
        drvOe = 4'b1101;
        #15;
    endtask

    // hold moves apart from data changes
    task automatic hold(input bit h);
        #5;
        drv[3] = h;
        #5;
    endtask

    // drive after fall, capture at rise
    task automatic xfer(input logic [7:0] v, input int n, input bit quad);
        for (int i = 0; i < n; i++) begin
            sck = 1'b0;
            if (quad) begin
                drv   = v[7:4];
                drvOe = 4'hf;
                v     = v << 4;
            end else begin
                drv[0] = v[7];
                v      = v << 1;
            end
            #15;
            sck = 1'b1;
            cap = quad ? {cap[19:0], line} : {cap[22:0], line[1]};
            #15;
        end
    endtask

    // chip enable rises first so the idle clock edge falls outside the frame
    task automatic desel();
        ceN   = 1'b1;
        drvOe = 4'h0;
        #3;
        sck   = cpol;
    endtask
endmodule
